// ==== hw/insn_decode_defs.svh ====
// field positions, opcode and function values for the instruction decoder
// assumes 32-bit instruction words, opcode in the top six bits
`ifndef INSN_DECODE_DEFS_SVH
`define INSN_DECODE_DEFS_SVH

// ==========================================================
// field positions
`define INSN_WIDTH        32
`define OPC_MSB           31
`define OPC_LSB           26
`define FP_FUNC_MSB       15
`define FP_FUNC_LSB       5
`define MEM_FUNC_MSB      15
`define MEM_FUNC_LSB      0
`define BR_HINT_MSB       15
`define BR_HINT_LSB       14
`define OPR_FUNC_MSB      11
`define OPR_FUNC_LSB      5
`define PAL_FUNC_MSB      25
`define PAL_FUNC_LSB      0

// ==========================================================
// primary opcodes
`define OPC_PAL           6'h00
`define OPC_INT_ARITH     6'h10
`define OPC_INT_LOGIC     6'h11
`define OPC_FP_VAXLIKE    6'h15
`define OPC_FP_IEEE       6'h16
`define OPC_MISC_MFC      6'h18
`define OPC_JUMP_MBR      6'h1A

// ==========================================================
// function codes
`define FN_ADD32          7'h00
`define FN_ADD32_TRAP     7'h40
`define FN_ADD64          7'h20
`define FN_ADD64_TRAP     7'h60
`define FN_ARCH_MASK      7'h61
`define FN_FP_ADD_SINGLE  11'h080
`define FN_FP_ADD_DOUBLE  11'h0A0

`endif

// ==== hw/insn_decode_pkg.sv ====
// types shared by the instruction decoder files
// assumes nothing beyond the defs header
package insn_decode_pkg;

  // ==========================================================
  // instruction format classes
  typedef enum logic [2:0] {
    FMT_BRANCH  = 3'h0,
    FMT_FLOAT   = 3'h1,
    FMT_MEMORY  = 3'h2,
    FMT_MEMFUNC = 3'h3,
    FMT_MEMBR   = 3'h4,
    FMT_OPERATE = 3'h5,
    FMT_PRIVLIB = 3'h6,
    FMT_NONE    = 3'h7
  } format_type;

  // ==========================================================
  // decoded operations
  typedef enum logic [3:0] {
    OP_NOP          = 4'h0,
    OP_ADD32        = 4'h1,
    OP_ADD32_TRAP   = 4'h2,
    OP_ADD64        = 4'h3,
    OP_ADD64_TRAP   = 4'h4,
    OP_FADD_F_SGL   = 4'h5,
    OP_FADD_F_DBL   = 4'h6,
    OP_FADD_I_SGL   = 4'h7,
    OP_FADD_I_DBL   = 4'h8,
    OP_ARCH_MASK    = 4'h9,
    OP_LIB_CALL     = 4'hA,
    OP_ILLEGAL      = 4'hF
  } op_type;

endpackage

// ==== hw/format_classifier.sv ====
// maps a primary opcode onto its instruction format class
// assumes a purely combinational use inside the decode stage
`timescale 1ns/1ns
`default_nettype none
`include "insn_decode_defs.svh"

module format_classifier
  import insn_decode_pkg::*;
(
  // opcode in
  input  wire logic [5:0] opcode,
  // class out
  output format_type      formatClass
);

  // ==========================================================
  // opcode to format
  always_comb begin
    unique case (opcode)
      `OPC_PAL:                     formatClass = FMT_PRIVLIB;
      `OPC_INT_ARITH,
      `OPC_INT_LOGIC,
      6'h12, 6'h13, 6'h1C:          formatClass = FMT_OPERATE;
      `OPC_FP_VAXLIKE,
      `OPC_FP_IEEE,
      6'h14, 6'h17:                 formatClass = FMT_FLOAT;
      `OPC_MISC_MFC:                formatClass = FMT_MEMFUNC;
      `OPC_JUMP_MBR:                formatClass = FMT_MEMBR;
      default: begin
        if (opcode[5:4] == 2'b11) begin
          formatClass = FMT_BRANCH;
        end else if (opcode[5] || (opcode[5:3] == 3'b001)) begin
          formatClass = FMT_MEMORY;
        end else begin
          formatClass = FMT_NONE;
        end
      end
    endcase
  end

endmodule
`default_nettype wire

// ==== hw/instruction_format_decoder.sv ====
// decode stage: splits an instruction word into opcode and format fields
// assumes fetch presents one word per cycle with a valid strobe
`timescale 1ns/1ns
`default_nettype none
`include "insn_decode_defs.svh"

module instruction_format_decoder
  import insn_decode_pkg::*;
#(
  parameter int INSN_BITS = `INSN_WIDTH
)
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // from fetch
  input  wire logic                   inValid,
  input  wire logic [INSN_BITS-1:0]   inWord,
  // to execution
  output logic                        outValid,
  output logic [5:0]                  outOpcode,
  output format_type                  outFormat,
  output op_type                      outOp,
  output logic                        outTrapOverflow,
  output logic                        outWide64,
  output logic                        outIllegal,
  // format fields
  output logic [10:0]                 outFpFunc,
  output logic [15:0]                 outMemFunc,
  output logic [1:0]                  outBranchHint,
  output logic [6:0]                  outOprFunc,
  output logic [25:0]                 outLibFunc,
  output logic [15:0]                 outDisplacement
);

  // ==========================================================
  // elaboration check
  if (INSN_BITS != 32) begin : g_width_check
    $error("instruction_format_decoder serves 32-bit words only");
  end

  // ==========================================================
  // field helpers
  function automatic logic [6:0] oprFuncOf(input logic [31:0] w);
    oprFuncOf = w[`OPR_FUNC_MSB:`OPR_FUNC_LSB];
  endfunction

  function automatic logic [10:0] fpFuncOf(input logic [31:0] w);
    fpFuncOf = w[`FP_FUNC_MSB:`FP_FUNC_LSB];
  endfunction

  // ==========================================================
  // combinational decode
  logic [5:0]   opcodeNow;
  format_type   formatNow;
  op_type       op_next;
  logic         trap_next;
  logic         wide_next;
  logic [10:0]  fpFunc_next;
  logic [15:0]  memFunc_next;
  logic [1:0]   hint_next;
  logic [6:0]   oprFunc_next;
  logic [25:0]  libFunc_next;
  logic [15:0]  disp_next;

  assign opcodeNow = inWord[`OPC_MSB:`OPC_LSB];

  format_classifier u_classifier (
    .opcode      (opcodeNow),
    .formatClass (formatNow)
  );

  // fields are only meaningful in their own format
  always_comb begin
    fpFunc_next  = 11'h000;
    memFunc_next = 16'h0000;
    hint_next    = 2'b00;
    oprFunc_next = 7'h00;
    libFunc_next = 26'h000_0000;
    disp_next    = 16'h0000;
    unique case (formatNow)
      FMT_FLOAT:   fpFunc_next  = fpFuncOf(inWord);
      FMT_MEMFUNC: memFunc_next = inWord[`MEM_FUNC_MSB:`MEM_FUNC_LSB];
      FMT_MEMBR: begin
        hint_next = inWord[`BR_HINT_MSB:`BR_HINT_LSB];
        disp_next = inWord[15:0];
      end
      FMT_OPERATE: oprFunc_next = oprFuncOf(inWord);
      FMT_PRIVLIB: libFunc_next = inWord[`PAL_FUNC_MSB:`PAL_FUNC_LSB];
      FMT_MEMORY:  disp_next    = inWord[15:0];
      FMT_BRANCH,
      FMT_NONE:    disp_next    = 16'h0000;
    endcase
  end

  // operation identity
  always_comb begin
    op_next   = OP_ILLEGAL;
    trap_next = 1'b0;
    wide_next = 1'b0;
    unique case (opcodeNow)
      `OPC_INT_ARITH: begin
        unique case (oprFuncOf(inWord))
          `FN_ADD32:      op_next = OP_ADD32;
          `FN_ADD32_TRAP: begin
            op_next   = OP_ADD32_TRAP;
            trap_next = 1'b1;
          end
          `FN_ADD64: begin
            op_next   = OP_ADD64;
            wide_next = 1'b1;
          end
          `FN_ADD64_TRAP: begin
            op_next   = OP_ADD64_TRAP;
            wide_next = 1'b1;
            trap_next = 1'b1;
          end
          default:        op_next = OP_ILLEGAL;
        endcase
      end
      `OPC_INT_LOGIC: begin
        if (oprFuncOf(inWord) == `FN_ARCH_MASK) begin
          op_next   = OP_ARCH_MASK;
          wide_next = 1'b1;
        end
      end
      `OPC_FP_VAXLIKE: begin
        if (fpFuncOf(inWord) == `FN_FP_ADD_SINGLE) begin
          op_next = OP_FADD_F_SGL;
        end else if (fpFuncOf(inWord) == `FN_FP_ADD_DOUBLE) begin
          op_next   = OP_FADD_F_DBL;
          wide_next = 1'b1;
        end
      end
      `OPC_FP_IEEE: begin
        if (fpFuncOf(inWord) == `FN_FP_ADD_SINGLE) begin
          op_next = OP_FADD_I_SGL;
        end else if (fpFuncOf(inWord) == `FN_FP_ADD_DOUBLE) begin
          op_next   = OP_FADD_I_DBL;
          wide_next = 1'b1;
        end
      end
      `OPC_PAL:           op_next = OP_LIB_CALL;
      default:            op_next = OP_ILLEGAL;
    endcase
  end

  // ==========================================================
  // valid and operation registers
  logic    valid_reg;
  op_type  op_reg;
  logic    trap_reg;
  logic    wide_reg;
  logic    illegal_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      valid_reg   <= 1'b0;
      op_reg      <= OP_NOP;
      trap_reg    <= 1'b0;
      wide_reg    <= 1'b0;
      illegal_reg <= 1'b0;
    end else if (inValid) begin
      valid_reg   <= 1'b1;
      op_reg      <= op_next;
      trap_reg    <= trap_next;
      wide_reg    <= wide_next;
      illegal_reg <= (op_next == OP_ILLEGAL);
    end else begin
      valid_reg   <= 1'b0;
      op_reg      <= OP_NOP;
      trap_reg    <= 1'b0;
      wide_reg    <= 1'b0;
      illegal_reg <= 1'b0;
    end
  end

  // ==========================================================
  // field registers
  logic [5:0]   opcode_reg;
  format_type   format_reg;
  logic [10:0]  fpFunc_reg;
  logic [15:0]  memFunc_reg;
  logic [1:0]   hint_reg;
  logic [6:0]   oprFunc_reg;
  logic [25:0]  libFunc_reg;
  logic [15:0]  disp_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !inValid) begin
      opcode_reg  <= 6'h00;
      format_reg  <= FMT_NONE;
      fpFunc_reg  <= 11'h000;
      memFunc_reg <= 16'h0000;
      hint_reg    <= 2'b00;
      oprFunc_reg <= 7'h00;
      libFunc_reg <= 26'h000_0000;
      disp_reg    <= 16'h0000;
    end else begin
      opcode_reg  <= opcodeNow;
      format_reg  <= formatNow;
      fpFunc_reg  <= fpFunc_next;
      memFunc_reg <= memFunc_next;
      hint_reg    <= hint_next;
      oprFunc_reg <= oprFunc_next;
      libFunc_reg <= libFunc_next;
      disp_reg    <= disp_next;
    end
  end

  // ==========================================================
  // outputs
  assign outValid        = valid_reg;
  assign outOpcode       = opcode_reg;
  assign outFormat       = format_reg;
  assign outOp           = op_reg;
  assign outTrapOverflow = trap_reg;
  assign outWide64       = wide_reg;
  assign outIllegal      = illegal_reg;
  assign outFpFunc       = fpFunc_reg;
  assign outMemFunc      = memFunc_reg;
  assign outBranchHint   = hint_reg;
  assign outOprFunc      = oprFunc_reg;
  assign outLibFunc      = libFunc_reg;
  assign outDisplacement = disp_reg;

endmodule
`default_nettype wire

// ==== sim/fetch_model.sv ====
// fetch side model: presents one word per call
// assumes the caller steps it just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module fetch_model (
  // to decoder
  output logic        inValid,
  output logic [31:0] inWord
);
  task automatic send(input logic v, input logic [31:0] w);
    inValid = v;
    inWord  = v ? w : ~w;
  endtask
endmodule
`default_nettype wire

// ==== sim/instruction_format_decoder_sva.sv ====
// checker for the instruction decoder ports
// assumes one clock, synchronous active low reset
`timescale 1ns/1ns
`default_nettype none
module decoder_checker
  import insn_decode_pkg::*;
#(
  parameter int INSN_BITS = 32
)
(
  // watched ports
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 inValid,
  input wire logic [INSN_BITS-1:0] inWord,
  input wire logic                 outValid,
  input wire logic [5:0]           outOpcode,
  input wire format_type           outFormat,
  input wire op_type               outOp,
  input wire logic                 outTrapOverflow,
  input wire logic                 outWide64,
  input wire logic                 outIllegal,
  input wire logic [10:0]          outFpFunc,
  input wire logic [15:0]          outMemFunc,
  input wire logic [1:0]           outBranchHint,
  input wire logic [6:0]           outOprFunc,
  input wire logic [25:0]          outLibFunc
);
  logic [INSN_BITS-1:0] wordPrev_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys) wordPrev_reg <= inWord;
  a_valid_follows: assert property (inValid |=> outValid) else $error("no valid");
  a_idle_nop: assert property (!inValid |=> !outValid && outOp == OP_NOP && outFormat == FMT_NONE)
    else $error("idle not nop");
  a_opcode_copy: assert property (outValid |-> outOpcode == wordPrev_reg[31:26])
    else $error("opcode");
  a_add_plain: assert property (inValid && inWord[31:26] == 6'h10 && inWord[11:5] == 7'h00
    |=> outOp == OP_ADD32 && !outWide64 && !outTrapOverflow) else $error("add32");
  a_add_trap32: assert property (inValid && inWord[31:26] == 6'h10 && inWord[11:5] == 7'h40
    |=> outOp == OP_ADD32_TRAP && !outWide64 && outTrapOverflow) else $error("add32 trap");
  a_add_wide: assert property (inValid && inWord[31:26] == 6'h10 && inWord[11:5] == 7'h20
    |=> outOp == OP_ADD64 && outWide64 && !outTrapOverflow) else $error("add64");
  a_add_trap64: assert property (inValid && inWord[31:26] == 6'h10 && inWord[11:5] == 7'h60
    |=> outOp == OP_ADD64_TRAP && outWide64 && outTrapOverflow) else $error("add64 trap");
  a_fp_field: assert property (outFormat == FMT_FLOAT |-> outFpFunc == wordPrev_reg[15:5])
    else $error("fp");
  a_mem_field: assert property (outFormat == FMT_MEMFUNC |-> outMemFunc == wordPrev_reg[15:0])
    else $error("mem");
  a_hint_field: assert property (outFormat == FMT_MEMBR |-> outBranchHint == wordPrev_reg[15:14])
    else $error("hint");
  a_opr_field: assert property (outFormat == FMT_OPERATE |-> outOprFunc == wordPrev_reg[11:5])
    else $error("opr");
  a_lib_call: assert property (inValid && inWord[31:26] == 6'h00
    |=> outOp == OP_LIB_CALL && outLibFunc == wordPrev_reg[25:0]) else $error("lib");
  a_illegal_flag: assert property (outIllegal |-> outValid && outOp == OP_ILLEGAL)
    else $error("illegal");
  a_branch_unknown: assert property (inValid && inWord[31:30] == 2'b11
    |=> outIllegal && outOp == OP_ILLEGAL && outFormat == FMT_BRANCH) else $error("branch not flagged");
endmodule
bind instruction_format_decoder decoder_checker #(.INSN_BITS(INSN_BITS)) chk_i (.clk_sys, .rst_n, .inValid,
  .inWord, .outValid, .outOpcode, .outFormat, .outOp, .outTrapOverflow, .outWide64, .outIllegal, .outFpFunc,
  .outMemFunc, .outBranchHint, .outOprFunc, .outLibFunc);
`default_nettype wire

// ==== sim/instruction_format_decoder_tb_top.sv ====
// testbench for the instruction decoder
// assumes the fetch model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module instruction_format_decoder_tb_top
  import insn_decode_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        inValid, outValid, outTrapOverflow, outWide64, outIllegal;
  logic [31:0] inWord, w;
  logic [5:0]  outOpcode;
  format_type  outFormat;
  op_type      outOp;
  logic [10:0] outFpFunc;
  logic [15:0] outMemFunc, outDisplacement;
  logic [1:0]  outBranchHint;
  logic [6:0]  outOprFunc;
  logic [25:0] outLibFunc;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [31:0] corner [19] = '{32'h4000_0000, 32'h4000_0800, 32'h4000_0400, 32'h4000_0C00, 32'h4400_0C20,
    32'h5400_1000, 32'h5400_1400, 32'h5800_1000, 32'h5800_1400, 32'h5400_1020, 32'h0123_4567, 32'h6000_ABCD,
    32'h6800_C123, 32'h2000_FFFF, 32'hC012_3456, 32'h4000_0020, 32'h1000_0000, 32'h7000_0000, 32'hFFFF_FFFF};
  always #25 clk_sys = ~clk_sys;
  fetch_model fetch (.inValid, .inWord);
  instruction_format_decoder #(.INSN_BITS(32)) uut (.clk_sys, .rst_n, .inValid, .inWord, .outValid, .outOpcode,
    .outFormat, .outOp, .outTrapOverflow, .outWide64, .outIllegal, .outFpFunc, .outMemFunc, .outBranchHint,
    .outOprFunc, .outLibFunc, .outDisplacement);
  // ==========================================================
  // expectations and compares
  function automatic format_type expFmt(input logic [5:0] o);
    if (o == 6'h00) return FMT_PRIVLIB;
    if (o inside {[6'h10:6'h13], 6'h1C}) return FMT_OPERATE;
    if (o inside {[6'h14:6'h17]}) return FMT_FLOAT;
    if (o == 6'h18) return FMT_MEMFUNC;
    if (o == 6'h1A) return FMT_MEMBR;
    if (o >= 6'h30) return FMT_BRANCH;
    if (o inside {[6'h08:6'h0F], [6'h20:6'h2F]}) return FMT_MEMORY;
    return FMT_NONE;
  endfunction
  function automatic op_type expOp(input logic [31:0] x);
    if (x[31:26] == 6'h00) return OP_LIB_CALL;
    case ({x[31:26], x[11:5]})
      {6'h10, 7'h00}: return OP_ADD32;
      {6'h10, 7'h40}: return OP_ADD32_TRAP;
      {6'h10, 7'h20}: return OP_ADD64;
      {6'h10, 7'h60}: return OP_ADD64_TRAP;
      {6'h11, 7'h61}: return OP_ARCH_MASK;
      default: ;
    endcase
    case ({x[31:26], x[15:5]})
      {6'h15, 11'h080}: return OP_FADD_F_SGL;
      {6'h15, 11'h0A0}: return OP_FADD_F_DBL;
      {6'h16, 11'h080}: return OP_FADD_I_SGL;
      {6'h16, 11'h0A0}: return OP_FADD_I_DBL;
      default: ;
    endcase
    return OP_ILLEGAL;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: field got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkOp(input op_type g, input op_type e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: op got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input logic v, input logic [31:0] x);
    format_type f;
    op_type     p;
    fetch.send(v, x);
    @(posedge clk_sys);
    #1;
    f = v ? expFmt(x[31:26]) : FMT_NONE;
    p = v ? expOp(x) : OP_NOP;
    chk(outValid, v);
    chk(outOpcode, v ? x[31:26] : 6'h00);
    chk(outFormat, f);
    chkOp(outOp, p);
    chk(outTrapOverflow, p inside {OP_ADD32_TRAP, OP_ADD64_TRAP});
    chk(outWide64, p inside {OP_ADD64, OP_ADD64_TRAP, OP_ARCH_MASK, OP_FADD_F_DBL, OP_FADD_I_DBL});
    chk(outIllegal, p == OP_ILLEGAL);
    chk(outFpFunc, f == FMT_FLOAT ? x[15:5] : 11'h000);
    chk(outMemFunc, f == FMT_MEMFUNC ? x[15:0] : 16'h0000);
    chk(outBranchHint, f == FMT_MEMBR ? x[15:14] : 2'h0);
    chk(outOprFunc, f == FMT_OPERATE ? x[11:5] : 7'h00);
    chk(outLibFunc, f == FMT_PRIVLIB ? x[25:0] : 26'h000_0000);
    chk(outDisplacement, f inside {FMT_MEMORY, FMT_MEMBR} ? x[15:0] : 16'h0000);
  endtask
  task automatic holdReset(input int n);
    rst_n = 1'b0;
    fetch.send(1'b1, 32'h4000_0C00);
    repeat (n) @(posedge clk_sys);
    #1;
    chk(outValid, 1'b0);
    chkOp(outOp, OP_NOP);
    chk(outFormat, FMT_NONE);
    rst_n = 1'b1;
    $display("test reset done");
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    void'($urandom(23384));
    holdReset(6);
    foreach (corner[i]) step(1'b1, corner[i]);
    step(1'b0, 32'h4000_0400);
    $display("test corner done");
    repeat (300) begin
      w = $urandom;
      if (w[0]) w[31:27] = 5'h08;
      if (w[1]) w[10:5] = w[2] ? 6'h20 : 6'h00;
      step($urandom_range(3, 0) != 0, w);
    end
    $display("test random done");
    holdReset(2);
    step(1'b1, 32'h4000_0C00);
    step(1'b1, 32'h4000_0800);
    $display("test rereset done");
    final_report();
  end
  initial begin
    #(1000 * 50);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
